//--- rtl/fks_pkg.sv
// Package of constants and types for the flash key and read strobe block
package fks_pkg;
    // Register addresses on the special function register port
    localparam logic [7:0] ADDR_ONESHOT  = 8'hAF;  // Read strobe one-shot register
    localparam logic [7:0] ADDR_TIMING   = 8'hB6;  // Flash read timing register
    localparam logic [7:0] ADDR_KEY      = 8'hB7;  // Flash unlock key register
    localparam logic [7:0] ADDR_PROGRAM_STORE_CONTROL    = 8'h8F;  // Program store control register
    // Key codes
    localparam logic [7:0] KEY_FIRST     = 8'hA5;
    localparam logic [7:0] KEY_SECOND    = 8'hF1;
    // Field positions and reset values
    localparam int         TIMING_RT_BIT = 4;      // Read time double bit position
    localparam int         PS_WE_BIT     = 0;      // Program store write enable
    localparam int         PS_EE_BIT     = 1;      // Program store erase enable
    localparam logic [7:0] TIMING_RESET  = 8'h03;  // Reset value of the timing register
    localparam logic [3:0] PERIOD_RESET  = 4'hF;   // One-shot period at reset (80 ns)
    localparam logic [7:0] TIMING_RD_MSK = 8'h10;  // Only the read time bit reads back
    // Timing figures
    localparam int         CLK_PERIOD_NS = 100;    // System clock period
    localparam int         STEP_NS       = 5;      // One-shot step and base
    localparam int         HALF_FAST_NS  = 80;     // 12.5 MHz period threshold
    // Reserved program memory on the larger variant
    localparam logic [15:0] RSVD_LO      = 16'h7E00;
    localparam logic [15:0] RSVD_HI      = 16'h7FFF;
    localparam logic [15:0] PAGE_MASK    = 16'hFE00;  // 512-byte erase page
    // Internal lock states of the key sequence; lock_code gives the value read back from the key register
    typedef enum logic [1:0] {
        LK_LOCKED   = 2'b00,
        LK_FIRST    = 2'b01,
        LK_UNLOCKED = 2'b11,
        LK_DISABLED = 2'b10
    } fks_lock_t;
    // Encode the internal state into its read code
    function automatic logic [1:0] lock_code(input fks_lock_t s);
        case (s)
            LK_LOCKED:   lock_code = 2'h0;
            LK_FIRST:    lock_code = 2'h1;
            LK_UNLOCKED: lock_code = 2'h2;
            LK_DISABLED: lock_code = 2'h3;
            default:     lock_code = 2'h3;
        endcase
    endfunction
endpackage

//--- rtl/fks_strobe_if.sv
// Interface carrying the read strobe settings and request between modules
`timescale 1ns/1ps
interface fks_strobe_if;
    logic       rd_req;      // Read or fetch request this cycle
    logic       rt_double;   // Two-clock strobe selected
    logic [3:0] period;      // One-shot period field
    logic       strobe;      // Read strobe, active high
    logic       busy;        // Strobe still covering the read
    modport ctrl (output rd_req, output rt_double, output period, input strobe, input busy);
    modport gen  (input rd_req, input rt_double, input period, output strobe, output busy);
endinterface

//--- rtl/fks_strobe_gen.sv
// Read strobe generator with one- or two-clock length and one-shot cut-off
`timescale 1ns/1ps
module fks_strobe_gen
    import fks_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    fks_strobe_if.gen sif,
    output logic      shot_on_o
);
    // Fast clocks engage the one-shot only for double reads: otherwise the clock period bounds the strobe
    localparam logic SLOW_CLOCK = (CLK_PERIOD_NS > HALF_FAST_NS);

    typedef struct packed {
        logic       active;  // Strobe window open
        logic       second;  // In second clock of a double strobe
    } fks_sg_t;

    fks_sg_t st, next_st;

    // Next-state logic of the strobe window
    always_comb begin
        next_st = st;
        if (sif.rd_req && !st.active) begin
            next_st.active = 1'b1;
            next_st.second = 1'b0;
        end else if (st.active && sif.rt_double && !st.second) begin
            next_st.second = 1'b1;
        end else if (sif.rd_req) begin
            next_st.second = 1'b0;
        end else begin
            next_st.active = 1'b0;
            next_st.second = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // One-shot enable: period field only matters on slow clocks or double reads
    assign shot_on_o  = SLOW_CLOCK || sif.rt_double;
    // Strobe held for the active clock(s); flash idles otherwise
    assign sif.strobe = st.active;
    assign sif.busy   = st.active && sif.rt_double && !st.second;
endmodule

//--- rtl/fks_top.sv
// Flash key sequencer, lock readback, program store routing and read strobe control
// Operation
// - Key A5 then F1 permits one write
// - Permission withdrawn after the next operation
// - Bad key or illegal write locks until reset
// - Non-A5 first key locks flash deliberately
// - Key read returns two-bit lock state
// - Reset timing valid up to 25 MHz
// - Strobe one or two clocks per read
// - Flash active only while strobe asserted
// - Slow clock: one-shot ends the strobe
// - Mid clocks: clock period sets width
// - Period field sets width 5+5n ns
// - Period ignored when fast and single
// - Timing reserved bits read zero
// - One-shot upper nibble reads zero, ignored
// - Top 512 bytes reserved on large part
// - Write-enable routes external writes to flash
// - Both enables make writes erase page
`timescale 1ns/1ps
module fks_top
    import fks_pkg::*;
#(
    parameter logic LARGE_VARIANT = 1'b1    // Larger device with reserved top area
)(
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic [7:0]  reg_addr_i,      // Special function register address
    input  wire logic        reg_wr_i,        // Register write strobe
    input  wire logic        reg_rd_i,        // Register read strobe
    input  wire logic [7:0]  reg_wdata_i,     // Register write data
    output logic      [7:0]  reg_rdata_o,     // Register read data
    input  wire logic        mem_rd_i,        // Flash read or fetch request
    input  wire logic [15:0] xmove_addr_i,    // External move address
    input  wire logic        xmove_wr_i,      // External move write strobe
    input  wire logic [7:0]  xmove_wdata_i,   // External move write data
    input  wire logic        flash_done_i,    // Flash write or erase completed
    output logic             flash_strobe_o,  // Flash read strobe
    output logic             oneshot_en_o,    // One-shot limiter enabled
    output logic      [3:0]  oneshot_per_o,   // One-shot period field to analog timer
    output logic             flash_wr_o,      // Flash byte write pulse
    output logic             flash_erase_o,   // Flash page erase pulse
    output logic      [15:0] flash_addr_o,    // Flash write or erase address
    output logic      [7:0]  flash_wdata_o,   // Flash write data
    output logic             xram_wr_o,       // External move write routed to data RAM
    output logic             flash_busy_o     // Write or erase in progress
);
    // Whole state of the block, apart from the strobe generator's window, in one record
    typedef struct packed {
        fks_lock_t   lock;       // Key sequence state
        logic        rt_double;  // Two-clock read strobe
        logic [3:0]  period;     // One-shot period
        logic        ps_we;      // Program store write enable
        logic        ps_ee;      // Program store erase enable
        logic        op_busy;    // Write or erase outstanding
        logic        fl_wr;      // Write pulse
        logic        fl_er;      // Erase pulse
        logic        xr_wr;      // Data RAM write pulse
        logic [15:0] fl_addr;    // Captured flash address
        logic [7:0]  fl_data;    // Captured flash data
        logic [7:0]  rdata;      // Register read data
    } fks_state_t;

    fks_state_t st, next_st;

    fks_strobe_if sif();

    logic shot_on;               // One-shot active from the strobe generator

    // Address inside the reserved top area of the large variant
    function automatic logic in_reserved(input logic [15:0] a);
        in_reserved = LARGE_VARIANT && (a >= RSVD_LO) && (a <= RSVD_HI);
    endfunction

    // Read strobe generator
    fks_strobe_gen u_strobe (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .sif       (sif),
        .shot_on_o (shot_on)
    );

    assign sif.rd_req    = mem_rd_i;
    assign sif.rt_double = st.rt_double;
    assign sif.period    = st.period;

    // Register, key sequence and write routing
    always_comb begin
        logic fl_target;
        logic key_wr;
        fl_target = 1'b0;
        key_wr    = 1'b0;
        next_st       = st;
        next_st.fl_wr = 1'b0;
        next_st.fl_er = 1'b0;
        next_st.xr_wr = 1'b0;

        // Register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_KEY: begin
                    key_wr = 1'b1;
                end
                ADDR_TIMING: begin
                    next_st.rt_double = reg_wdata_i[TIMING_RT_BIT];
                end
                ADDR_ONESHOT: begin
                    next_st.period = reg_wdata_i[3:0];
                end
                ADDR_PROGRAM_STORE_CONTROL: begin
                    next_st.ps_we = reg_wdata_i[PS_WE_BIT];
                    next_st.ps_ee = reg_wdata_i[PS_EE_BIT];
                end
                default: begin
                end
            endcase
        end

        // Key sequence
        if (key_wr) begin
            case (st.lock)
                LK_LOCKED: begin
                    // Any other first key locks, which also guards unused flash
                    next_st.lock = (reg_wdata_i == KEY_FIRST) ? LK_FIRST
                                                              : LK_DISABLED;
                end
                LK_FIRST: begin
                    next_st.lock = (reg_wdata_i == KEY_SECOND) ? LK_UNLOCKED
                                                               : LK_DISABLED;
                end
                LK_UNLOCKED: begin
                    next_st.lock = LK_DISABLED;
                end
                default: begin
                    next_st.lock = LK_DISABLED;
                end
            endcase
        end

        // External move write: flash when write enable set, else data RAM
        fl_target = xmove_wr_i && st.ps_we;
        if (xmove_wr_i && !st.ps_we) begin
            next_st.xr_wr = 1'b1;
        end
        if (fl_target) begin
            if (st.lock == LK_UNLOCKED && !st.op_busy && !key_wr
                    && !in_reserved(xmove_addr_i)) begin
                next_st.op_busy = 1'b1;
                next_st.fl_data = xmove_wdata_i;
                if (st.ps_ee) begin
                    next_st.fl_er   = 1'b1;
                    next_st.fl_addr = xmove_addr_i & PAGE_MASK;
                end else begin
                    next_st.fl_wr   = 1'b1;
                    next_st.fl_addr = xmove_addr_i;
                end
            end else begin
                // Attempt while not permitted locks until reset
                next_st.lock = LK_DISABLED;
            end
        end

        // Completion withdraws permission; a key write in the same cycle still locks
        if (st.op_busy && flash_done_i) begin
            next_st.op_busy = 1'b0;
            if (next_st.lock != LK_DISABLED) begin
                next_st.lock = LK_LOCKED;
            end
        end

        // Register read data
        next_st.rdata = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_KEY:     next_st.rdata = {6'h00, lock_code(st.lock)};
                ADDR_TIMING:  next_st.rdata = {3'h0, st.rt_double, 4'h0};
                ADDR_ONESHOT: next_st.rdata = {4'h0, st.period};
                ADDR_PROGRAM_STORE_CONTROL:   next_st.rdata = {6'h00, st.ps_ee, st.ps_we};
                default:      next_st.rdata = '0;
            endcase
        end
    end

    // State register; reset brings single-clock reads and the locked key state
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st           <= '0;
            st.lock      <= LK_LOCKED;
            st.rt_double <= TIMING_RESET[TIMING_RT_BIT];
            st.period    <= PERIOD_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign reg_rdata_o    = st.rdata;
    assign flash_strobe_o = sif.strobe;
    assign oneshot_en_o   = shot_on;
    assign oneshot_per_o  = st.period;
    assign flash_wr_o     = st.fl_wr;
    assign flash_erase_o  = st.fl_er;
    assign flash_addr_o   = st.fl_addr;
    assign flash_wdata_o  = st.fl_data;
    assign xram_wr_o      = st.xr_wr;
    assign flash_busy_o   = st.op_busy;
endmodule

//--- tb/fks_checker.sv
// Concurrent assertions on the ports of the flash key and read strobe block
`timescale 1ns/1ps
module fks_checker #(
    parameter logic LARGE_VARIANT = 1'b1   // Larger part keeps its top area reserved
)(
    input wire logic        clk_sys_i,
    input wire logic        nrst_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        mem_rd_i,
    input wire logic        xmove_wr_i,
    input wire logic        flash_strobe_o,
    input wire logic        oneshot_en_o,
    input wire logic        flash_wr_o,
    input wire logic        flash_erase_o,
    input wire logic [15:0] flash_addr_o,
    input wire logic        xram_wr_o,
    input wire logic        flash_busy_o
);
    // One clock domain, so clocking and reset are stated once
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // Every read gets a strobe; a gap of two idle requests ends it
    a_strobe_follows_read: assert property (mem_rd_i |=> flash_strobe_o)
        else $error("read strobe missing after a read request");
    a_strobe_released: assert property (!mem_rd_i ##1 !mem_rd_i |=> !flash_strobe_o)
        else $error("read strobe held past its length");
    // At this slow clock the limiter must always be in charge
    a_oneshot_active: assert property (oneshot_en_o)
        else $error("one-shot limiter not enabled at slow clock");
    // Writes only ever come from an external move, to one target
    a_write_has_cause: assert property ((flash_wr_o || flash_erase_o || xram_wr_o)
        |-> $past(xmove_wr_i))
        else $error("write pulse without an external move");
    a_one_target: assert property ($onehot0({flash_wr_o, flash_erase_o, xram_wr_o}))
        else $error("write sent to more than one target");
    a_erase_page_base: assert property (flash_erase_o |-> flash_addr_o[8:0] == 9'h000)
        else $error("erase address not on a page boundary");
    // Reserved top area is never touched on the larger part
    a_reserved_safe: assert property ((flash_wr_o || flash_erase_o) |-> (!LARGE_VARIANT
        || !(flash_addr_o inside {[16'h7E00:16'h7FFF]})))
        else $error("write or erase reached the reserved area");
    // One permitted operation, then busy and no second pulse
    a_op_sets_busy: assert property ((flash_wr_o || flash_erase_o) |-> ##[0:1] flash_busy_o)
        else $error("busy not raised by a flash operation");
    a_single_op: assert property ((flash_wr_o || flash_erase_o)
        |=> !(flash_wr_o || flash_erase_o))
        else $error("second flash operation on one unlock");
    a_no_op_while_busy: assert property ((flash_busy_o && $past(flash_busy_o))
        |-> !(flash_wr_o || flash_erase_o))
        else $error("flash operation started while one is outstanding");
    // Read data is zero outside its answer cycle
    a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data driven without a read");
endmodule
bind fks_top fks_checker #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (.*);

//--- tb/fks_flash_model.sv
// Flash array model: answers each write or erase with a done pulse
`timescale 1ns/1ps
module fks_flash_model (
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    input  wire logic       wr_i,          // Byte write pulse from the block
    input  wire logic       erase_i,       // Page erase pulse from the block
    input  wire logic [3:0] dly_i,         // Cycles of programming time, prompt or slow
    output logic            done_o         // Completion pulse back to the block
);
    logic [4:0] cnt;                       // Remaining busy cycles, zero when idle
    // Count down the programming time, then pulse done once
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt    <= 5'h00;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt == 5'h01);                  // Ends the permitted operation
            if (wr_i || erase_i) begin
                cnt <= {1'b0, dly_i} + 5'h01;
            end else if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
            end
        end
    end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the flash key and read strobe block
`timescale 1ns/1ps
module testbench;
    import fks_pkg::*;
    logic        clk_sys_i, nrst_i, reg_wr_i, reg_rd_i, mem_rd_i, xmove_wr_i, flash_done_i;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, xmove_wdata_i, flash_wdata_o;
    logic [15:0] xmove_addr_i, flash_addr_o, seed;
    logic [3:0]  oneshot_per_o, fm_dly;
    logic        flash_strobe_o, oneshot_en_o, flash_wr_o, flash_erase_o, xram_wr_o;
    logic        flash_busy_o, pend;
    int          failures, checks_done, swid;
    logic [7:0]  rq[$];   // Expected read data
    logic [18:0] oq[$];   // Expected {xram, erase, write, address}
    logic [7:0]  dq[$];   // Expected flash write data
    int          sq[$];   // Expected strobe widths

    fks_top DUT (.*);
    fks_flash_model u_fm (.clk_sys_i, .nrst_i, .wr_i(flash_wr_o), .erase_i(flash_erase_o),
        .dly_i(fm_dly), .done_o(flash_done_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [15:0] lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task cmp(input string nm, input logic [18:0] e, input logic [18:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Drive just after the edge; wr and rd leave one idle cycle behind them, mr four
    task tick; @(posedge clk_sys_i); #1; endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a; reg_wdata_i = d; reg_wr_i = 1'b1; tick; reg_wr_i = 1'b0; tick;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        rq.push_back(e); reg_addr_i = a; reg_rd_i = 1'b1; tick; reg_rd_i = 1'b0; tick;
    endtask
    task key(input logic [7:0] k, input logic [7:0] e); wr(ADDR_KEY, k); rd(ADDR_KEY, e); endtask
    // External move write; zero expectation means no pulse may appear
    task xw(input logic [15:0] a, input logic [18:0] e);
        seed = lf(seed);
        if (e != 19'h0) oq.push_back(e);
        if (e[16]) dq.push_back(seed[7:0]);
        xmove_addr_i = a; xmove_wdata_i = seed[7:0]; xmove_wr_i = 1'b1; tick;
        xmove_wr_i = 1'b0; repeat (2) tick;
        for (int i = 0; i < 40 && flash_busy_o !== 1'b0; i++) tick;
        // A flash that never finishes counts as a mismatch
        if (flash_busy_o !== 1'b0) failures++;
    endtask
    task mr(input int w); sq.push_back(w); mem_rd_i = 1'b1; tick; mem_rd_i = 1'b0; repeat (4) tick; endtask
    task rst; nrst_i = 1'b0; repeat (3) tick; nrst_i = 1'b1; tick; endtask
    task fin(input string n); $display("test %s finished", n); endtask
    task end_of_test;
        if (rq.size() + oq.size() + sq.size() != 0) failures++;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Watcher samples at the falling edge, where outputs have settled
    always @(negedge clk_sys_i) begin
        if (pend && rq.size() != 0)
            cmp("reg_rdata_o", {11'h0, rq.pop_front()}, {11'h0, reg_rdata_o});
        pend = reg_rd_i;
        if (flash_wr_o || flash_erase_o || xram_wr_o)
            cmp("flash op", oq.size() != 0 ? oq.pop_front() : 19'h0,
                xram_wr_o ? 19'h40000 : {1'b0, flash_erase_o, flash_wr_o, flash_addr_o});
        if (flash_wr_o)
            cmp("flash_wdata_o", {11'h0, dq.size() != 0 ? dq.pop_front() : 8'h00},
                {11'h0, flash_wdata_o});
        if (flash_strobe_o === 1'b1) swid++;
        else if (swid != 0) begin
            cmp("strobe width", 19'(sq.size() != 0 ? sq.pop_front() : 0), 19'(swid));
            swid = 0;
        end
    end

    initial begin
        #200000;
        failures++;
        end_of_test;
    end

    initial begin
        {reg_wr_i, reg_rd_i, mem_rd_i, xmove_wr_i, reg_addr_i, reg_wdata_i} = '0;
        {xmove_addr_i, xmove_wdata_i, failures, checks_done, swid, pend} = '0;
        seed = 16'hEDB3; fm_dly = 4'h1;
        rst;
        rd(ADDR_KEY, 8'h00);
        rd(ADDR_TIMING, 8'h00);
        rd(ADDR_ONESHOT, {4'h0, PERIOD_RESET});
        rd(8'h00, 8'h00); rd(ADDR_PROGRAM_STORE_CONTROL, 8'h00);
        mr(1);
        fin("reset");
        // Reserved timing bits are written as zeros, as software must
        wr(ADDR_TIMING, 8'h10); rd(ADDR_TIMING, TIMING_RD_MSK);
        mr(2);
        wr(ADDR_TIMING, 8'h00); mr(1);
        repeat (4) begin
            seed = lf(seed);
            // Period kept at 45 ns or more; upper nibble random and ignored
            wr(ADDR_ONESHOT, {seed[7:4], 1'b1, seed[2:0]});
            rd(ADDR_ONESHOT, {5'h01, seed[2:0]});
            cmp("oneshot_per_o", {15'h0, 1'b1, seed[2:0]}, {15'h0, oneshot_per_o});
        end
        fin("strobe");
        key(KEY_FIRST, 8'h01);
        key(KEY_SECOND, 8'h02);
        wr(ADDR_PROGRAM_STORE_CONTROL, 8'h01); xw(16'h1234, {3'b001, 16'h1234});
        rd(ADDR_KEY, 8'h00);
        fm_dly = 4'h9; key(KEY_FIRST, 8'h01); key(KEY_SECOND, 8'h02);
        wr(ADDR_PROGRAM_STORE_CONTROL, 8'h03); xw(16'h1234, {3'b010, 16'h1200});
        rd(ADDR_KEY, 8'h00);
        wr(ADDR_PROGRAM_STORE_CONTROL, 8'h00); xw(16'h0100, 19'h40000);
        fin("program");
        key(KEY_FIRST, 8'h01); key(KEY_SECOND, 8'h02);
        wr(ADDR_PROGRAM_STORE_CONTROL, 8'h01); xw(16'h7E10, 19'h0);
        rd(ADDR_KEY, 8'h03); key(KEY_FIRST, 8'h03);
        rst; rd(ADDR_KEY, 8'h00);
        key(8'h00, 8'h03);
        rst; wr(ADDR_PROGRAM_STORE_CONTROL, 8'h01); xw(16'h0200, 19'h0); rd(ADDR_KEY, 8'h03);
        rst; key(KEY_FIRST, 8'h01); key(8'h5A, 8'h03);
        fin("lock");
        end_of_test;
    end
endmodule
